// ---- design/tnm_map.svh ----
/*
 * Constants of the two-wire nonvolatile memory slave: timing, field positions,
 * sizes and reset values.
 * Assumes it is included by its bare name from design files only.
 */
`ifndef TNM_MAP_SVH
`define TNM_MAP_SVH

// system clock period and the spike width that the line filter suppresses
`define TNM_MCLK_PERIOD_NS 50
`define TNM_SPIKE_NS 100
`define TNM_SPIKE_CYC ((`TNM_SPIKE_NS + `TNM_MCLK_PERIOD_NS - 1) / `TNM_MCLK_PERIOD_NS)

// shortest bus clock phase at 1 MHz and the sync stages ahead of the filter
`define TNM_SCL_HALF_MIN_NS 500
`define TNM_SYNC_STAGES 2

// slave address byte layout
`define TNM_SLA_TYPE_MSB 7
`define TNM_SLA_TYPE_LSB 4
`define TNM_SLA_SEL_MSB 3
`define TNM_SLA_SEL_LSB 1
`define TNM_SLA_RW_BIT 0

// array geometry and bus address width
`define TNM_MEM_ADDR_W 13
`define TNM_MEM_DATA_W 8
`define TNM_BUS_ADDR_W 16
`define TNM_SEL_W 3

// byte framing and reset values
`define TNM_BITS_PER_BYTE 4'h8
`define TNM_CNT_RST 4'h0
`define TNM_SHREG_RST 8'h00

`endif

// ---- design/tnm_pkg.sv ----
/*
 * Types of the two-wire nonvolatile memory slave: protocol states and the
 * structs that carry the bus lines and the bus events.
 * Assumes nothing of its surroundings.
 */
package tnm_pkg;

   typedef enum logic [2:0] {
      TNM_IDLE,
      TNM_DEV,
      TNM_AHI,
      TNM_ALO,
      TNM_WR,
      TNM_RD
   } tnm_state_e;

   typedef struct packed {
      logic scl;
      logic sda;
   } tnm_line_s;

   typedef struct packed {
      logic start;
      logic stop;
      logic rise;
      logic fall;
   } tnm_ev_s;

endpackage : tnm_pkg

// ---- design/tnm_sync.sv ----
/*
 * Two-flop synchroniser followed by a stability filter for a group of pins.
 * Assumes din is asynchronous to clk and rst is synchronous, active high.
 */
`timescale 1ns/10ps
`default_nettype none

module tnm_sync #(
   parameter int WIDTH = 1,
   parameter int STABLE = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic clk, // system clock
   input wire logic rst, // synchronous reset, active high
   input wire logic [WIDTH-1:0] din, // asynchronous pin levels
   output logic [WIDTH-1:0] dout // synchronised, filtered levels
);

   localparam int CW = (STABLE < 2) ? 1 : $clog2(STABLE + 1);

   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] sync_r;
   logic [WIDTH-1:0] last_r;
   logic [CW-1:0] stable_r;

   if (STABLE < 1) begin : g_chk
      $error("tnm_sync: STABLE must be at least 1");
   end

   always_ff @(posedge clk) begin
      // reset to the idle level of the pins so no false edge follows reset
      if (rst) begin
         meta_r <= RST_VAL;
         sync_r <= RST_VAL;
      end else begin
         meta_r <= din;
         sync_r <= meta_r;
      end
   end

   // output follows only a level that held for STABLE + 1 samples
   always_ff @(posedge clk) begin
      if (rst) begin
         last_r <= RST_VAL;
         stable_r <= '0;
         dout <= RST_VAL;
      end else begin
         last_r <= sync_r;
         if (sync_r != last_r) begin
            stable_r <= '0;
         end else if (stable_r != CW'(STABLE - 1)) begin
            stable_r <= stable_r + 1'b1;
         end else begin
            dout <= sync_r;
         end
      end
   end

endmodule : tnm_sync

`default_nettype wire

// ---- design/tnm_slave.sv ----
/*
 * Slave logic of a serial nonvolatile memory on a two-wire bus: line filter,
 * start/stop detection, slave address match, 13-bit address capture, byte
 * write and sequential read of the 8192 x 8 array, write protection.
 * Assumes SCL and SDA arrive from pads as plain inputs, the open-drain pad
 * drives low while SDA_OE is high, and pad pull-downs hold unused pins low.
 */
`timescale 1ns/10ps
`default_nettype none

`include "tnm_map.svh"

module tnm_slave
   import tnm_pkg::*;
#(
   parameter int ADDR_W = `TNM_MEM_ADDR_W,
   // device type code; value is arbitrary
   parameter logic [3:0] DEV_TYPE = 4'h5,
   parameter int SPIKE_CYC = `TNM_SPIKE_CYC
) (
   input wire logic MCLK, // system clock, 20 MHz
   input wire logic RESET, // synchronous reset, active high
   input wire logic SCL_I, // bus clock level from pad
   input wire logic SDA_I, // bus data level from pad
   output logic SDA_O, // data output level, always low
   output logic SDA_OE, // high while pulling data low
   input wire logic [`TNM_SEL_W-1:0] DEVICE_SELECT_PINS, // strapped select address
   input wire logic WRITE_PROTECT, // high protects the whole array
   output logic SELECTED // high while addressed in a transaction
);

   localparam int DEPTH = 2 ** ADDR_W;
   localparam int HI_W = ADDR_W - 8;
   // event latency in system clocks against the shortest bus clock phase
   localparam int SCL_HALF_CYC = `TNM_SCL_HALF_MIN_NS / `TNM_MCLK_PERIOD_NS;
   localparam int EVENT_LAT_CYC = `TNM_SYNC_STAGES + SPIKE_CYC + 2;
   // bus lines idle high; the filter starts there so reset makes no false edge
   localparam logic [1:0] LINE_IDLE = 2'h3;

   if (ADDR_W < 9 || ADDR_W > `TNM_BUS_ADDR_W) begin : g_chk_addr
      $error("tnm_slave: ADDR_W must lie in 9..16");
   end
   if (SPIKE_CYC < 1) begin : g_chk_spike
      $error("tnm_slave: SPIKE_CYC must be at least 1");
   end
   // output must turn round well inside a 1 MHz low phase
   if (EVENT_LAT_CYC >= SCL_HALF_CYC) begin : g_chk_rate
      $error("tnm_slave: line filter too slow for a 1 MHz bus clock");
   end

   logic [1:0] line_vec;
   tnm_line_s line_f;
   tnm_line_s line_q_r;
   tnm_ev_s ev;
   logic [`TNM_SEL_W:0] pins_vec;
   logic [`TNM_SEL_W-1:0] sel_f;
   logic wp_f;

   tnm_state_e state_r;
   tnm_state_e state_nxt;
   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;
   logic ack_ph_r;
   logic ack_ph_nxt;
   logic rw_r;
   logic rw_nxt;
   logic mack_r;
   logic mack_nxt;
   logic [7:0] shreg_r;
   logic [7:0] shreg_nxt;
   logic [ADDR_W-1:0] addr_r;
   logic [ADDR_W-1:0] addr_nxt;
   logic [HI_W-1:0] addr_hi_r;
   logic [HI_W-1:0] addr_hi_nxt;
   logic sda_oe_nxt;
   logic mem_we;
   logic sla_match;
   logic [7:0] rd_data;
   logic byte_done;
   logic rd_shift;

   logic [`TNM_MEM_DATA_W-1:0] mem_r [0:DEPTH-1];

   tnm_sync #(
      .WIDTH(2),
      .STABLE(SPIKE_CYC),
      .RST_VAL(LINE_IDLE)
   ) u_line_sync (
      .clk(MCLK),
      .rst(RESET),
      .din({SCL_I, SDA_I}),
      .dout(line_vec)
   );

   tnm_sync #(
      .WIDTH(`TNM_SEL_W + 1),
      .STABLE(1),
      .RST_VAL(4'h0)
   ) u_pin_sync (
      .clk(MCLK),
      .rst(RESET),
      .din({WRITE_PROTECT, DEVICE_SELECT_PINS}),
      .dout(pins_vec)
   );

   assign line_f = line_vec;
   assign sel_f = pins_vec[`TNM_SEL_W-1:0];
   assign wp_f = pins_vec[`TNM_SEL_W];
   assign rd_data = mem_r[addr_r];
   // eight bits counted: a whole byte has been shifted in or out
   assign byte_done = (cnt_r == `TNM_BITS_PER_BYTE);
   // read bits after the first leave on the falls that follow bit clocks
   assign rd_shift = (state_r == TNM_RD) && (cnt_r != `TNM_CNT_RST);

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         line_q_r <= '{scl: 1'b1, sda: 1'b1};
      end else begin
         line_q_r <= line_f;
      end
   end

   // bus conditions from the filtered lines
   always_comb begin
      ev.start = line_f.scl & line_q_r.scl & line_q_r.sda & ~line_f.sda;
      ev.stop = line_f.scl & line_q_r.scl & ~line_q_r.sda & line_f.sda;
      ev.rise = line_f.scl & ~line_q_r.scl;
      ev.fall = ~line_f.scl & line_q_r.scl;
   end

   // type code and select bits must match
   assign sla_match = (shreg_r[`TNM_SLA_TYPE_MSB:`TNM_SLA_TYPE_LSB] == DEV_TYPE) &&
                      (shreg_r[`TNM_SLA_SEL_MSB:`TNM_SLA_SEL_LSB] == sel_f);

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      ack_ph_nxt = ack_ph_r;
      rw_nxt = rw_r;
      mack_nxt = mack_r;
      shreg_nxt = shreg_r;
      addr_nxt = addr_r;
      addr_hi_nxt = addr_hi_r;
      sda_oe_nxt = SDA_OE;
      mem_we = 1'b0;
      // start or stop aborts whatever runs
      if (ev.start) begin
         state_nxt = TNM_DEV;
         cnt_nxt = `TNM_CNT_RST;
         ack_ph_nxt = 1'b0;
         sda_oe_nxt = 1'b0;
      end else if (ev.stop) begin
         state_nxt = TNM_IDLE;
         cnt_nxt = `TNM_CNT_RST;
         ack_ph_nxt = 1'b0;
         sda_oe_nxt = 1'b0;
      end else if (ev.rise) begin
         if (ack_ph_r) begin
            mack_nxt = ~line_f.sda;
         end else if (state_r != TNM_IDLE && !byte_done) begin
            cnt_nxt = cnt_r + 1'b1;
            if (state_r != TNM_RD) begin
               shreg_nxt = {shreg_r[6:0], line_f.sda};
            end
         end
      end else if (ev.fall) begin
         if (ack_ph_r) begin
            // acknowledge clock over: release and move on
            ack_ph_nxt = 1'b0;
            cnt_nxt = `TNM_CNT_RST;
            sda_oe_nxt = 1'b0;
            unique case (state_r)
               TNM_IDLE: state_nxt = TNM_IDLE;
               TNM_DEV: state_nxt = rw_r ? TNM_RD : TNM_AHI;
               TNM_AHI: state_nxt = TNM_ALO;
               TNM_ALO: state_nxt = TNM_WR;
               TNM_WR: state_nxt = TNM_WR;
               TNM_RD: state_nxt = mack_r ? TNM_RD : TNM_IDLE;
            endcase
            // first read bit goes out on this falling edge
            if (state_nxt == TNM_RD) begin
               shreg_nxt = rd_data;
               // pull low for a zero, release for a one
               sda_oe_nxt = ~rd_data[7];
            end
         end else if (byte_done) begin
            unique case (state_r)
               TNM_IDLE: state_nxt = TNM_IDLE;
               TNM_DEV: begin
                  if (sla_match) begin
                     rw_nxt = shreg_r[`TNM_SLA_RW_BIT];
                     ack_ph_nxt = 1'b1;
                     sda_oe_nxt = 1'b1;
                  end else begin
                     state_nxt = TNM_IDLE;
                  end
               end
               TNM_AHI: begin
                  addr_hi_nxt = shreg_r[HI_W-1:0];
                  ack_ph_nxt = 1'b1;
                  sda_oe_nxt = 1'b1;
               end
               TNM_ALO: begin
                  addr_nxt = {addr_hi_r, shreg_r};
                  ack_ph_nxt = 1'b1;
                  sda_oe_nxt = 1'b1;
               end
               TNM_WR: begin
                  // protected byte: no ack, no increment
                  if (!wp_f) begin
                     mem_we = 1'b1;
                     // increment before the acknowledge, natural wrap
                     addr_nxt = addr_r + 1'b1;
                     ack_ph_nxt = 1'b1;
                     sda_oe_nxt = 1'b1;
                  end else begin
                     state_nxt = TNM_IDLE;
                     sda_oe_nxt = 1'b0;
                  end
               end
               TNM_RD: begin
                  // read byte done, step the latch
                  addr_nxt = addr_r + 1'b1;
                  mack_nxt = 1'b0;
                  ack_ph_nxt = 1'b1;
                  sda_oe_nxt = 1'b0;
               end
            endcase
         end else if (rd_shift) begin
            // next read bit on the falling edge
            shreg_nxt = {shreg_r[6:0], 1'b0};
            sda_oe_nxt = ~shreg_r[6];
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         state_r <= TNM_IDLE;
         rw_r <= 1'b0;
         mack_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         rw_r <= rw_nxt;
         mack_r <= mack_nxt;
      end
   end

   // bit counter and acknowledge phase frame every byte
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         cnt_r <= `TNM_CNT_RST;
         ack_ph_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         ack_ph_r <= ack_ph_nxt;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         shreg_r <= `TNM_SHREG_RST;
      end else begin
         shreg_r <= shreg_nxt;
      end
   end

   // address latch keeps its value across transactions
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         addr_r <= '0;
         addr_hi_r <= '0;
      end else begin
         addr_r <= addr_nxt;
         addr_hi_r <= addr_hi_nxt;
      end
   end

   // array write port, no reset: contents are nonvolatile
   always_ff @(posedge MCLK) begin
      if (mem_we) begin
         mem_r[addr_r] <= shreg_r;
      end
   end

   // open-drain data only; no clock output exists
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         SDA_OE <= 1'b0;
      end else begin
         SDA_OE <= sda_oe_nxt;
      end
   end

   // data level is a constant low; only the enable moves
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         SDA_O <= 1'b0;
      end else begin
         SDA_O <= 1'b0;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         SELECTED <= 1'b0;
      end else begin
         SELECTED <= (state_nxt != TNM_IDLE) && (state_nxt != TNM_DEV);
      end
   end

endmodule : tnm_slave

`default_nettype wire

// ---- tb/tnm_slave_monitor.sv ----
/* assertions on the ports of the two-wire memory slave.
   assumes bind to tnm_slave; SCL_I, SDA_I are the wired pad levels. */
`timescale 1ns/10ps
`default_nettype none
module tnm_slave_monitor (
   input wire logic MCLK, // system clock
   input wire logic RESET, // sync reset
   input wire logic SCL_I, // bus clock
   input wire logic SDA_I, // bus data
   input wire logic SDA_O, // data level out
   input wire logic SDA_OE, // data pull enable
   input wire logic SELECTED // addressed status
);
   logic [8:0] oe_cnt_r;
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (RESET);
   sequence bus_start;
      SCL_I && $fell(SDA_I);
   endsequence
   sequence bus_stop;
      SCL_I && $rose(SDA_I);
   endsequence
   always_ff @(posedge MCLK) begin
      oe_cnt_r <= (RESET || !SDA_OE) ? 9'h000 : oe_cnt_r + 9'h001;
   end
   a_out_low: assert property (!SDA_O)
      else $error("data output level not low");
   a_reset_idle: assert property (@(posedge MCLK) disable iff (1'b0)
      RESET |=> !SDA_OE && !SELECTED) else $error("outputs active after reset");
   a_oe_scl_low: assert property ($changed(SDA_OE) |-> !SCL_I && !$past(SCL_I, 2))
      else $error("data changed while clock high");
   a_oe_hold: assert property ($rose(SDA_OE) |=> SDA_OE [*8])
      else $error("data pull too short");
   a_sel_rise: assert property ($rose(SELECTED) |-> !SCL_I && $past(SDA_OE))
      else $error("selected rose outside ack end");
   a_stop_clear: assert property (bus_stop |-> ##[1:10] !SELECTED && !SDA_OE)
      else $error("stop did not idle the slave");
   a_start_clear: assert property (bus_start |-> ##[1:10] !SELECTED)
      else $error("start did not deselect");
   a_oe_bounded: assert property (oe_cnt_r < 9'h190)
      else $error("data held low too long");
endmodule : tnm_slave_monitor
`default_nettype wire

// ---- tb/tnm_master_model.sv ----
/* two-wire bus master model, clocked by the link clock.
   assumes sda is the pulled-up wired data level. */
`timescale 1ns/10ps
`default_nettype none
module tnm_master_model (
   input wire logic lclk, // link clock
   input wire logic sda, // wired data level
   output logic scl, // bus clock
   output logic sda_lo // pulls data low
);
   localparam int HALF = 6;
   initial begin
      scl = 1'b1;
      sda_lo = 1'b0;
   end
   task automatic wt();
      repeat (HALF) @(posedge lclk);
   endtask : wt
   task automatic start();
      @(posedge lclk);
      sda_lo <= 1'b0;
      wt();
      scl <= 1'b1;
      wt();
      sda_lo <= 1'b1;
      wt();
      scl <= 1'b0;
   endtask : start
   task automatic stop();
      @(posedge lclk);
      sda_lo <= 1'b1;
      wt();
      scl <= 1'b1;
      wt();
      sda_lo <= 1'b0;
      wt();
   endtask : stop
   task automatic bitx(input logic b, output logic r);
      @(posedge lclk);
      sda_lo <= !b;
      wt();
      scl <= 1'b1;
      wt();
      r = sda;
      scl <= 1'b0;
   endtask : bitx
   task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                       output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitx(d[i], q[i]);
      end
      bitx(last, r);
      ack = !r;
   endtask : xfer
endmodule : tnm_master_model
`default_nettype wire

// ---- tb/tnm_slave_test.sv ----
/* self-checking bench of the two-wire memory slave.
   assumes a pulled-up data wire and the master model on an 80 ns clock. */
`timescale 1ns/10ps
`default_nettype none
module tnm_slave_test;
   import tnm_pkg::*;
   // type code; value is arbitrary
   localparam logic [3:0] DEV = 4'h5;
   logic mclk = 1'b0;
   logic lclk = 1'b0;
   logic reset = 1'b1;
   logic wp = 1'b0;
   logic [2:0] pins = 3'h0;
   logic scl, sda_lo, sda_o, sda_oe, selected;
   wire logic sda;
   int miscompares = 0;
   int cmp_count = 0;
   assign sda = ~(sda_oe | sda_lo);
   always #25 mclk = ~mclk;
   always #40 lclk = ~lclk;
   tnm_slave #(.DEV_TYPE(DEV)) u_dut (.MCLK(mclk), .RESET(reset), .SCL_I(scl),
      .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe), .DEVICE_SELECT_PINS(pins),
      .WRITE_PROTECT(wp), .SELECTED(selected));
   tnm_master_model u_master (.lclk(lclk), .sda(sda), .scl(scl), .sda_lo(sda_lo));
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      cmp_count++;
      if (s !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic wb(input logic [7:0] d, input logic e);
      logic [7:0] q;
      logic k;
      u_master.xfer(d, 1'b1, q, k);
      chk("ack", {7'h00, e}, {7'h00, k});
   endtask : wb
   task automatic rb(input logic [7:0] e, input logic last);
      logic [7:0] q;
      logic k;
      u_master.xfer(8'hFF, last, q, k);
      chk("read data", e, q);
   endtask : rb
   task automatic addr(input logic [15:0] a, input logic rd);
      u_master.start();
      wb({DEV, 3'h0, 1'b0}, 1'b1);
      wb(a[15:8], 1'b1);
      wb(a[7:0], 1'b1);
      if (rd) begin
         u_master.start();
         wb({DEV, 3'h0, 1'b1}, 1'b1);
      end
   endtask : addr
   task automatic set_wp(input logic v);
      @(negedge mclk);
      wp = v;
      repeat (4) @(negedge mclk);
   endtask : set_wp
   task automatic s_select();
      @(negedge mclk);
      pins = 3'h5;
      repeat (4) @(negedge mclk);
      for (int s = 0; s < 8; s++) begin
         u_master.start();
         wb({DEV, s[2:0], 1'b0}, s == 5);
         repeat (8) @(negedge mclk);
         chk("selected", {7'h00, s == 5}, {7'h00, selected});
         u_master.stop();
      end
      u_master.start();
      wb({~DEV, 3'h5, 1'b0}, 1'b0);
      u_master.stop();
      @(negedge mclk);
      pins = 3'h0;
   endtask : s_select
   task automatic s_wrap();
      addr(16'h1FFE, 1'b0);
      wb(8'hA1, 1'b1);
      wb(8'hB2, 1'b1);
      wb(8'hC3, 1'b1);
      addr(16'h1FFE, 1'b1);
      rb(8'hA1, 1'b0);
      rb(8'hB2, 1'b0);
      rb(8'hC3, 1'b1);
      u_master.stop();
   endtask : s_wrap
   task automatic s_upper();
      addr(16'hE005, 1'b0);
      wb(8'h5A, 1'b1);
      u_master.stop();
      addr(16'h0005, 1'b1);
      rb(8'h5A, 1'b1);
      u_master.stop();
   endtask : s_upper
   task automatic s_protect();
      addr(16'h0010, 1'b0);
      wb(8'h11, 1'b1);
      wb(8'h12, 1'b1);
      u_master.stop();
      set_wp(1'b1);
      addr(16'h0011, 1'b0);
      wb(8'h99, 1'b0);
      u_master.stop();
      set_wp(1'b0);
      u_master.start();
      wb({DEV, 3'h0, 1'b1}, 1'b1);
      rb(8'h12, 1'b1);
      u_master.stop();
   endtask : s_protect
   task automatic s_abort();
      logic r;
      addr(16'h0020, 1'b0);
      wb(8'h77, 1'b1);
      u_master.stop();
      addr(16'h0020, 1'b0);
      for (int i = 0; i < 4; i++) begin
         u_master.bitx(1'b0, r);
      end
      addr(16'h0020, 1'b1);
      rb(8'h77, 1'b1);
      u_master.stop();
   endtask : s_abort
   initial begin
      repeat (100000) @(posedge mclk);
      miscompares++;
      print_verdict();
   end
   initial begin
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      reset = 1'b0;
      repeat (10) @(negedge mclk);
      chk("idle", 8'h00, {5'h00, sda_o, sda_oe, selected});
      s_select();
      s_wrap();
      s_upper();
      s_protect();
      s_abort();
      print_verdict();
   end
endmodule : tnm_slave_test
bind tnm_slave tnm_slave_monitor u_mon (.MCLK(MCLK), .RESET(RESET), .SCL_I(SCL_I),
   .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE(SDA_OE), .SELECTED(SELECTED));
`default_nettype wire
